// ---- hdl/uart_irq_clear_and_id.sv ----
// The AHB-Lite interface to the registers was left to the implementer.
`timescale 1ns/100ps
module uart_irq_clear_and_id #(
	// ident byte zero default is arbitrary, not a real part code
	parameter logic [7:0] IDENT_FOUR  = uart_irq_pkg::IDENT_FOUR_DEF,
	parameter logic [7:0] IDENT_FIVE  = uart_irq_pkg::IDENT_FIVE_DEF,
	parameter logic [7:0] IDENT_SIX   = uart_irq_pkg::IDENT_SIX_DEF,
	parameter logic [7:0] IDENT_SEVEN = uart_irq_pkg::IDENT_SEVEN_DEF,
	parameter logic [7:0] IDENT_ZERO  = uart_irq_pkg::IDENT_ZERO_DEF,
	parameter logic [7:0] IDENT_ONE   = uart_irq_pkg::IDENT_ONE_DEF
) (
	// clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// ahb-lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic        hready,
	input  wire logic [31:0] hwdata,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// one-cycle event pulses from the datapath, same clock
	input  wire logic        rx_event,
	input  wire logic        tx_event,
	input  wire logic        rx_timeout_event,
	input  wire logic        framing_event,
	input  wire logic        parity_event,
	input  wire logic        break_event,
	input  wire logic        overrun_event,
	// interrupt outputs
	output logic      [6:0]  masked_status,
	output logic             irq
);

	logic        wr_pend_reg;
	logic [11:0] wr_addr_reg;
	logic [31:0] hrdata_reg;
	logic [31:0] rd_next;
	logic [6:0]  raw_reg;
	logic [6:0]  raw_next;
	logic [6:0]  mask_reg;
	logic [6:0]  events;
	logic [6:0]  clear_bits;
	logic        addr_phase;
	logic        wr_clear;
	logic        wr_mask;

	// transfer is taken only when the previous one has finished
	assign addr_phase = hsel && hready &&
		(htrans == uart_irq_pkg::HTRANS_NONSEQ || htrans == uart_irq_pkg::HTRANS_SEQ);

	// zero wait states, never an error
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = hrdata_reg;

	// event vector in field order, receive in the lowest position
	assign events = {overrun_event, break_event, parity_event, framing_event,
		rx_timeout_event, tx_event, rx_event};

	assign wr_clear = wr_pend_reg && (wr_addr_reg == uart_irq_pkg::OFS_INTERRUPT_CLEAR);
	assign wr_mask  = wr_pend_reg && (wr_addr_reg == uart_irq_pkg::OFS_INTERRUPT_MASK);

	// only ones clear; reserved bits of the written word are ignored
	assign clear_bits = wr_clear ?
		hwdata[uart_irq_pkg::SRC_MSB:uart_irq_pkg::SRC_LSB] : 7'h00;

	// a fresh event must not be lost to a clear written in the same cycle
	assign raw_next = (raw_reg & ~clear_bits) | events;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 12'h000;
		end
		else if (hready)
		begin
			wr_pend_reg <= addr_phase && hwrite;
			wr_addr_reg <= {haddr[11:2], 2'b00};
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			raw_reg <= uart_irq_pkg::RAW_RESET;
		else
			raw_reg <= raw_next;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			mask_reg <= uart_irq_pkg::MASK_RESET;
		else if (wr_mask)
			mask_reg <= hwdata[uart_irq_pkg::SRC_MSB:uart_irq_pkg::SRC_LSB];
	end

	assign masked_status = raw_reg & mask_reg;
	assign irq           = |masked_status;

	// read mux; clear register is write-only and reads zero
	always_comb
	begin
		rd_next = 32'h00000000;
		case ({haddr[11:2], 2'b00})
			uart_irq_pkg::OFS_INTERRUPT_MASK:
				rd_next[uart_irq_pkg::SRC_MSB:uart_irq_pkg::SRC_LSB] = mask_reg;
			uart_irq_pkg::OFS_RAW_STATUS:
			begin
				rd_next = uart_irq_pkg::RAW_RSVD_READ;
				rd_next[uart_irq_pkg::SRC_MSB:uart_irq_pkg::SRC_LSB] = raw_reg;
			end
			uart_irq_pkg::OFS_MASKED_STATUS:
				rd_next[uart_irq_pkg::SRC_MSB:uart_irq_pkg::SRC_LSB] = masked_status;
			uart_irq_pkg::OFS_IDENT_BYTE_FOUR:  rd_next[7:0] = IDENT_FOUR;
			uart_irq_pkg::OFS_IDENT_BYTE_FIVE:  rd_next[7:0] = IDENT_FIVE;
			uart_irq_pkg::OFS_IDENT_BYTE_SIX:   rd_next[7:0] = IDENT_SIX;
			uart_irq_pkg::OFS_IDENT_BYTE_SEVEN: rd_next[7:0] = IDENT_SEVEN;
			uart_irq_pkg::OFS_IDENT_BYTE_ZERO:  rd_next[7:0] = IDENT_ZERO;
			uart_irq_pkg::OFS_IDENT_BYTE_ONE:   rd_next[7:0] = IDENT_ONE;
			default: rd_next = 32'h00000000;
		endcase
	end

	// sampled at the address phase so data stands for the whole data phase
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			hrdata_reg <= uart_irq_pkg::HRDATA_RESET;
		else if (addr_phase && !hwrite)
			hrdata_reg <= rd_next;
	end

endmodule : uart_irq_clear_and_id

// ---- hdl/uart_irq_pkg.sv ----
package uart_irq_pkg;

	// register byte offsets
	localparam logic [11:0] OFS_INTERRUPT_MASK   = 12'h038;
	localparam logic [11:0] OFS_RAW_STATUS       = 12'h03C;
	localparam logic [11:0] OFS_MASKED_STATUS    = 12'h040;
	localparam logic [11:0] OFS_INTERRUPT_CLEAR  = 12'h044;
	localparam logic [11:0] OFS_IDENT_BYTE_FOUR  = 12'hFD0;
	localparam logic [11:0] OFS_IDENT_BYTE_FIVE  = 12'hFD4;
	localparam logic [11:0] OFS_IDENT_BYTE_SIX   = 12'hFD8;
	localparam logic [11:0] OFS_IDENT_BYTE_SEVEN = 12'hFDC;
	localparam logic [11:0] OFS_IDENT_BYTE_ZERO  = 12'hFE0;
	localparam logic [11:0] OFS_IDENT_BYTE_ONE   = 12'hFE4;

	// source field: seven contiguous bits, receive lowest
	localparam int SRC_COUNT = 7;
	localparam int SRC_LSB   = 4;
	localparam int SRC_MSB   = 10;
	localparam int BIT_RX       = 4;
	localparam int BIT_TX       = 5;
	localparam int BIT_RX_TIMEOUT = 6;
	localparam int BIT_FRAMING  = 7;
	localparam int BIT_PARITY   = 8;
	localparam int BIT_BREAK    = 9;
	localparam int BIT_OVERRUN  = 10;

	// reset and fixed read values
	localparam logic [6:0]  MASK_RESET       = 7'h00;
	localparam logic [6:0]  RAW_RESET        = 7'h00;
	localparam logic [31:0] RAW_RSVD_READ    = 32'h0000000F;
	localparam logic [31:0] HRDATA_RESET     = 32'h00000000;

	// ident byte defaults
	localparam logic [7:0] IDENT_FOUR_DEF  = 8'h00;
	localparam logic [7:0] IDENT_FIVE_DEF  = 8'h00;
	localparam logic [7:0] IDENT_SIX_DEF   = 8'h00;
	localparam logic [7:0] IDENT_SEVEN_DEF = 8'h00;
	localparam logic [7:0] IDENT_ZERO_DEF  = 8'h5A;
	localparam logic [7:0] IDENT_ONE_DEF   = 8'h00;

	// AHB transfer type
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] HTRANS_SEQ    = 2'h3;

endpackage : uart_irq_pkg

// ---- verif/uart_irq_assertions.sv ----
`timescale 1ns/100ps
module uart_irq_assertions (
	// watched ports
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [31:0] hwdata,
	input wire logic [31:0] hrdata,
	input wire logic [6:0]  masked_status,
	input wire logic        irq,
	input wire logic        rx_event
);
	logic        clr_ph;
	logic [11:0] ra;
	wire         tk = hsel && htrans[1];
	// ra of zero means no read data phase
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			{clr_ph, ra} <= '0;
		else
			{clr_ph, ra} <= {tk && hwrite && haddr[11:0] == 12'h044, tk && !hwrite ? haddr[11:0] : 12'h000};
	end
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	clr_set_a: assert property (clr_ph && hwdata[4] && !rx_event |=> !masked_status[0])
		else $error("clear missed");
	clr_keep_a: assert property (clr_ph |=> !($past(masked_status & ~hwdata[10:4]) & ~masked_status))
		else $error("clear leak");
	clr_read_a: assert property (ra == 12'h044 |-> hrdata == 32'h0)
		else $error("clear reg read");
	id_high_a: assert property (ra[11:4] >= 8'hFD |-> hrdata[31:8] == 24'h0)
		else $error("ident upper");
	id_zero_a: assert property (ra == 12'hFE0 |-> hrdata == {24'h0, uart_irq_pkg::IDENT_ZERO_DEF})
		else $error("ident zero");
	id_one_a: assert property (ra == 12'hFE4 |-> hrdata == {24'h0, uart_irq_pkg::IDENT_ONE_DEF})
		else $error("ident one");
	irq_or_a: assert property (irq == |masked_status)
		else $error("irq mismatch");
	ev_wins_a: assert property (rx_event && masked_status[0] |=> masked_status[0])
		else $error("event lost");
endmodule : uart_irq_assertions

// ---- verif/tb_uart_irq_clear_and_id.sv ----
`timescale 1ns/100ps
module tb_uart_irq_clear_and_id;
	logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
	logic [31:0] haddr, hwdata, hrdata, q;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [6:0]  ev, ms, raw, m, c, r;
	int          failures = 0;
	int          n_tests = 0;
	logic [11:0] ta [10] = '{12'hFD0, 12'hFD4, 12'hFD8, 12'hFDC, 12'hFE0, 12'hFE4, 12'h044,
		12'h100, 12'h03C, 12'h038};
	uart_irq_clear_and_id dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
		.hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp, .rx_event(ev[0]),
		.tx_event(ev[1]), .rx_timeout_event(ev[2]), .framing_event(ev[3]),
		.parity_event(ev[4]), .break_event(ev[5]), .overrun_event(ev[6]), .masked_status(ms), .irq);
	// events ride in the data phase so a clear and an event can collide
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [6:0] e);
		hsel <= 1'h1;
		haddr <= {20'h0, a};
		htrans <= uart_irq_pkg::HTRANS_NONSEQ;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'h1);
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= d;
		ev <= e;
		do @(posedge hclk); while (hreadyout !== 1'h1);
		q = hrdata;
		ev <= 7'h0;
	endtask : xfer
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		n_tests++;
		if (g !== x)
		begin
			failures++;
			$display("[ERR] %0t got %h want %h", $time, g, x);
		end
	endtask : chk
	function automatic logic [31:0] rd_exp(input logic [11:0] a);
		return a == 12'hFE0 ? {24'h0, uart_irq_pkg::IDENT_ZERO_DEF} : a == 12'h03C ? 32'hF : 32'h0;
	endfunction : rd_exp
	task automatic give_verdict();
		$display("errors %0d checks %0d", failures, n_tests);
		if (failures == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : give_verdict
	initial
	begin
		hclk = 1'h0;
		forever #5 hclk = ~hclk;
	end
	initial
	begin
		#20000;
		failures++;
		give_verdict();
	end
	initial
	begin
		{hresetn, hsel, hwrite, htrans, haddr, hwdata, ev, raw} = '0;
		hsize = 3'h2;
		q = $urandom(32'h3564946C);
		repeat (4) @(posedge hclk);
		hresetn <= 1'h1;
		@(posedge hclk);
		foreach (ta[i])
		begin
			if (i < 9)
				xfer(1'h1, ta[i], 32'hFFFFFFFF, 7'h0);
			xfer(1'h0, ta[i], 32'h0, 7'h0);
			chk(q, rd_exp(ta[i]));
		end
		xfer(1'h1, 12'h038, 32'h7F0, 7'h0);
		xfer(1'h1, 12'h100, 32'h0, 7'h7F);
		raw = 7'h7F;
		for (int i = 0; i < 7; i++)
		begin
			xfer(1'h1, 12'h044, (32'h1 << (i + 4)) | (32'hFFFFF80F & $urandom), 7'h0);
			raw &= ~(7'h1 << i);
			// the clear lands at the edge the task returns on; look one edge later
			@(posedge hclk);
			chk({25'h0, ms}, {25'h0, raw});
		end
		repeat (24)
		begin
			m = 7'($urandom);
			c = 7'($urandom);
			r = 7'($urandom);
			xfer(1'h1, 12'h038, {21'h0, m, 4'h0}, 7'h0);
			xfer(1'h1, 12'h044, {21'h0, c, 4'h0}, r);
			raw = (raw & ~c) | r;
			xfer(1'h0, 12'h03C, 32'h0, 7'h0);
			chk(q, {21'h0, raw, 4'hF});
			chk({25'h0, ms}, {25'h0, raw & m});
			chk({31'h0, irq}, {31'h0, |(raw & m)});
			xfer(1'h0, 12'h040, 32'h0, 7'h0);
			chk(q, {21'h0, raw & m, 4'h0});
		end
		give_verdict();
	end
endmodule : tb_uart_irq_clear_and_id
bind uart_irq_clear_and_id uart_irq_assertions sva (.*);
